// ==== rtl/swcp_core.sv ====
// Notes on behaviour
// - only whole 8-byte rows from a row boundary are copyable
// - page code 55h: scratchpad gets existing memory, incoming data dropped
// - page code aah: scratchpad gets incoming data and memory ANDed
// - other page codes: incoming data stored unchanged
// - protection byte holding 55h or aah is itself locked
// - page code 55h alone does not block a copy; copy refreshes the page
// - copy protection 55h/aah blocks register row and write-protected pages
// - ending offset loads low address bits, increments per data byte after the first
// - status bit 5 set on power loss or short write
// - status byte is read only; bits 3, 4, 6 read zero
// - status bit 7 set when a copy is started; any scratchpad write clears it
// - nonzero low address bits on write block the following copy
// - scratchpad read sends address low, high, status, then data
// - standard speed after reset; overdrive only once switched
// - bad address or short writes are accepted, copy then blocked
// - write: 2 address bytes then data stored from low address offset
// - only complete bytes are stored; offset names the last one
// - write crc cleared, then command, address and data shifted in
// - at offset 7 the master may read the inverted crc
// - copy needs match, valid address, clear partial flag, no protection
// - page protection bytes at 0080h-0083h, copy protection at 0084h
`include "swcp_regs.svh"
`default_nettype none
module swcp_core (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic xfer_end_in,
  input wire logic rx_valid_in,
  input wire logic [7:0] rx_byte_in,
  input wire logic tx_ready_in,
  input wire logic od_set_in,
  input wire logic od_clr_in,
  input wire logic [7:0] mem_rd_data_in,
  input wire logic [31:0] prot_codes_in,
  input wire logic [7:0] copy_prot_in,
  input wire logic copy_done_in,
  output logic tx_valid_out,
  output logic [7:0] tx_byte_out,
  output logic [15:0] mem_addr_out,
  output logic copy_start_out,
  output logic [15:0] copy_addr_out,
  output logic [63:0] copy_data_out,
  output logic overdrive_flag_out
);
  // ----------------------------------------
  // state
  // ----------------------------------------
  swcp_pkg::swcp_state_t state_r;
  swcp_pkg::swcp_state_t state_nxt;
  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic [7:0] ta_lo_r;
  logic [7:0] ta_lo_nxt;
  logic [7:0] ta_hi_r;
  logic [7:0] ta_hi_nxt;
  logic [2:0] e_r;
  logic [2:0] e_nxt;
  logic pf_r;
  logic pf_nxt;
  logic aa_r;
  logic aa_nxt;
  logic wfirst_r;
  logic wfirst_nxt;
  logic [2:0] rofs_r;
  logic [2:0] rofs_nxt;
  logic auth_r;
  logic auth_nxt;
  logic [7:0] sp_r [8];
  logic [7:0] sp_nxt [8];
  logic [7:0] tx_byte_r;
  logic [7:0] tx_byte_nxt;
  logic tx_valid_r;
  logic tx_valid_nxt;
  logic copy_start_r;
  logic copy_start_nxt;
  logic od_r;
  logic od_nxt;
  logic [15:0] mem_addr_r;
  logic [15:0] mem_addr_nxt;

  logic crc_clr;
  logic crc_en;
  logic [7:0] crc_data;
  logic [15:0] crc_val;
  logic [15:0] addr_w;
  logic [2:0] wofs;
  logic [7:0] es_w;
  logic [7:0] page_code;
  logic [7:0] merged;
  logic addr_ok;
  logic cp_block;

  // ----------------------------------------
  // derived terms
  // ----------------------------------------
  assign addr_w = {ta_hi_r, ta_lo_r};
  assign wofs = wfirst_r ? e_r : e_r + 3'h1;
  assign es_w = {aa_r, 1'b0, pf_r, 2'b00, e_r};
  assign page_code = prot_codes_in[{ta_lo_r[6:5], 3'b000} +: 8];
  assign addr_ok = (addr_w < `SWCP_ADDR_LIMIT) && (ta_lo_r[2:0] == 3'h0);
  // a 55h page alone never blocks, so a refresh copy is possible
  assign cp_block = (copy_prot_in == `SWCP_CODE_WP || copy_prot_in == `SWCP_CODE_EPROM) &&
                    ((addr_w >= `SWCP_ADDR_PROT0) ||
                     (page_code == `SWCP_CODE_WP));

  swcp_merge swcp_merge_inst (
    .addr_in({addr_w[15:3], wofs}),
    .new_in(rx_byte_in),
    .old_in(mem_rd_data_in),
    .prot_codes_in(prot_codes_in),
    .byte_out(merged)
  );

  swcp_crc16 swcp_crc16_inst (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .clr_in(crc_clr),
    .en_in(crc_en),
    .data_in(crc_data),
    .crc_out(crc_val)
  );

  // ----------------------------------------
  // command sequencer
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    ta_lo_nxt = ta_lo_r;
    ta_hi_nxt = ta_hi_r;
    e_nxt = e_r;
    pf_nxt = pf_r;
    aa_nxt = aa_r;
    wfirst_nxt = wfirst_r;
    rofs_nxt = rofs_r;
    auth_nxt = auth_r;
    sp_nxt = sp_r;
    tx_byte_nxt = tx_byte_r;
    tx_valid_nxt = 1'b0;
    copy_start_nxt = 1'b0;
    crc_clr = 1'b0;
    crc_en = 1'b0;
    crc_data = rx_byte_in;
    // memory read runs one cycle ahead of the byte that needs it
    mem_addr_nxt = {addr_w[15:3], wofs};
    od_nxt = od_r;
    if (od_clr_in) begin
      od_nxt = 1'b0;
    end else if (od_set_in) begin
      od_nxt = 1'b1;
    end
    if (tx_ready_in) begin
      tx_valid_nxt = 1'b1;
      tx_byte_nxt = `SWCP_IDLE_BYTE;
    end
    if (xfer_end_in) begin
      state_nxt = swcp_pkg::st_cmd;
    end else begin
      unique case (state_r)
        swcp_pkg::st_cmd: begin
          if (rx_valid_in) begin
            crc_clr = 1'b1;
            crc_en = 1'b1;
            cnt_nxt = 2'h0;
            if (rx_byte_in == `SWCP_CMD_WRITE_SP) begin
              aa_nxt = 1'b0;
              pf_nxt = 1'b1;
              state_nxt = swcp_pkg::st_w_ta1;
            end else if (rx_byte_in == `SWCP_CMD_READ_SP) begin
              state_nxt = swcp_pkg::st_r_hdr;
            end else if (rx_byte_in == `SWCP_CMD_COPY_SP) begin
              auth_nxt = 1'b1;
              state_nxt = swcp_pkg::st_c_ta1;
            end else begin
              state_nxt = swcp_pkg::st_idle;
            end
          end
        end
        swcp_pkg::st_w_ta1: begin
          if (rx_valid_in) begin
            crc_en = 1'b1;
            ta_lo_nxt = rx_byte_in;
            e_nxt = rx_byte_in[2:0];
            wfirst_nxt = 1'b1;
            state_nxt = swcp_pkg::st_w_ta2;
          end
        end
        swcp_pkg::st_w_ta2: begin
          if (rx_valid_in) begin
            crc_en = 1'b1;
            ta_hi_nxt = rx_byte_in;
            state_nxt = swcp_pkg::st_w_data;
          end
        end
        swcp_pkg::st_w_data: begin
          // the link only presents complete bytes; a cut-off byte never shows
          if (rx_valid_in) begin
            crc_en = 1'b1;
            sp_nxt[wofs] = merged;
            e_nxt = wofs;
            wfirst_nxt = 1'b0;
            if (wofs == `SWCP_ES_LAST_OFS) begin
              pf_nxt = 1'b0;
              cnt_nxt = 2'h0;
              state_nxt = swcp_pkg::st_w_crc;
            end
          end
        end
        swcp_pkg::st_w_crc, swcp_pkg::st_r_crc: begin
          if (tx_ready_in) begin
            if (cnt_r == 2'h0) begin
              tx_byte_nxt = ~crc_val[7:0];
            end else if (cnt_r == 2'h1) begin
              tx_byte_nxt = ~crc_val[15:8];
            end
            if (cnt_r != 2'h2) begin
              cnt_nxt = cnt_r + 2'h1;
            end
          end
        end
        swcp_pkg::st_r_hdr: begin
          if (tx_ready_in) begin
            crc_en = 1'b1;
            if (cnt_r == 2'h0) begin
              tx_byte_nxt = ta_lo_r;
            end else if (cnt_r == 2'h1) begin
              tx_byte_nxt = ta_hi_r;
            end else begin
              tx_byte_nxt = es_w;
            end
            crc_data = tx_byte_nxt;
            if (cnt_r == 2'h2) begin
              rofs_nxt = ta_lo_r[2:0];
              state_nxt = swcp_pkg::st_r_data;
            end else begin
              cnt_nxt = cnt_r + 2'h1;
            end
          end
        end
        swcp_pkg::st_r_data: begin
          if (tx_ready_in) begin
            crc_en = 1'b1;
            tx_byte_nxt = sp_r[rofs_r];
            crc_data = sp_r[rofs_r];
            if (rofs_r == e_r) begin
              cnt_nxt = 2'h0;
              state_nxt = swcp_pkg::st_r_crc;
            end else begin
              rofs_nxt = rofs_r + 3'h1;
            end
          end
        end
        swcp_pkg::st_c_ta1: begin
          if (rx_valid_in) begin
            auth_nxt = auth_r && (rx_byte_in == ta_lo_r);
            state_nxt = swcp_pkg::st_c_ta2;
          end
        end
        swcp_pkg::st_c_ta2: begin
          if (rx_valid_in) begin
            auth_nxt = auth_r && (rx_byte_in == ta_hi_r);
            state_nxt = swcp_pkg::st_c_es;
          end
        end
        swcp_pkg::st_c_es: begin
          if (rx_valid_in) begin
            if (auth_r && rx_byte_in == es_w && addr_ok && !pf_r && !cp_block) begin
              aa_nxt = 1'b1;
              copy_start_nxt = 1'b1;
              state_nxt = swcp_pkg::st_c_busy;
            end else begin
              state_nxt = swcp_pkg::st_idle;
            end
          end
        end
        swcp_pkg::st_c_busy: begin
          if (copy_done_in) begin
            state_nxt = swcp_pkg::st_c_done;
          end
        end
        swcp_pkg::st_c_done: begin
          if (tx_ready_in) begin
            tx_byte_nxt = `SWCP_ALT_PATTERN;
          end
        end
        swcp_pkg::st_idle: begin
          state_nxt = swcp_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_r <= swcp_pkg::st_cmd;
      cnt_r <= 2'h0;
      ta_lo_r <= 8'h00;
      ta_hi_r <= 8'h00;
      e_r <= 3'h0;
      pf_r <= `SWCP_PF_RESET;
      aa_r <= `SWCP_AA_RESET;
      wfirst_r <= 1'b1;
      rofs_r <= 3'h0;
      auth_r <= 1'b0;
      for (int i = 0; i < 8; i++) begin
        sp_r[i] <= 8'hff;
      end
      tx_byte_r <= `SWCP_IDLE_BYTE;
      tx_valid_r <= 1'b0;
      copy_start_r <= 1'b0;
      od_r <= `SWCP_OD_RESET;
      mem_addr_r <= 16'h0000;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      ta_lo_r <= ta_lo_nxt;
      ta_hi_r <= ta_hi_nxt;
      e_r <= e_nxt;
      pf_r <= pf_nxt;
      aa_r <= aa_nxt;
      wfirst_r <= wfirst_nxt;
      rofs_r <= rofs_nxt;
      auth_r <= auth_nxt;
      sp_r <= sp_nxt;
      tx_byte_r <= tx_byte_nxt;
      tx_valid_r <= tx_valid_nxt;
      copy_start_r <= copy_start_nxt;
      od_r <= od_nxt;
      mem_addr_r <= mem_addr_nxt;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign tx_valid_out = tx_valid_r;
  assign tx_byte_out = tx_byte_r;
  assign mem_addr_out = mem_addr_r;
  assign copy_start_out = copy_start_r;
  assign copy_addr_out = addr_w;
  assign copy_data_out = {sp_r[7], sp_r[6], sp_r[5], sp_r[4],
                          sp_r[3], sp_r[2], sp_r[1], sp_r[0]};
  assign overdrive_flag_out = od_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);

  property p_write_flags;
    (state_r == swcp_pkg::st_cmd && rx_valid_in && !xfer_end_in &&
     rx_byte_in == `SWCP_CMD_WRITE_SP) |=> (!aa_r && pf_r);
  endproperty
  a_write_flags: assert property (p_write_flags)
    else $error("write command did not clear copy flag and set partial flag");

  property p_offset_load;
    (state_r == swcp_pkg::st_w_ta1 && rx_valid_in && !xfer_end_in)
      |=> (e_r == $past(rx_byte_in[2:0]) && wfirst_r);
  endproperty
  a_offset_load: assert property (p_offset_load)
    else $error("ending offset not loaded from low address bits");

  property p_store;
    (state_r == swcp_pkg::st_w_data && rx_valid_in && !xfer_end_in)
      |=> (sp_r[e_r] == $past(merged) && e_r == $past(wofs));
  endproperty
  a_store: assert property (p_store)
    else $error("scratchpad byte not stored from merge result");

  property p_status_zero;
    (state_r == swcp_pkg::st_r_hdr && cnt_r == 2'h2 && tx_ready_in && !xfer_end_in)
      |=> (tx_byte_out[6] == 1'b0 && tx_byte_out[4:3] == 2'b00 &&
           tx_byte_out[`SWCP_ES_PF_BIT] == pf_r && tx_valid_out);
  endproperty
  a_status_zero: assert property (p_status_zero)
    else $error("status byte unused bits not zero");

  property p_header_first;
    (state_r == swcp_pkg::st_r_hdr && cnt_r == 2'h0 && tx_ready_in && !xfer_end_in)
      |=> (tx_byte_out == ta_lo_r);
  endproperty
  a_header_first: assert property (p_header_first)
    else $error("scratchpad read did not start with address low");

  property p_crc_out;
    (state_r == swcp_pkg::st_w_crc && cnt_r == 2'h0 && tx_ready_in && !xfer_end_in)
      |=> (tx_byte_out == ~crc_val[7:0]);
  endproperty
  a_crc_out: assert property (p_crc_out)
    else $error("inverted crc low byte not returned");

  property p_copy_valid;
    copy_start_out |-> (copy_addr_out[2:0] == 3'h0 && !pf_r && aa_r &&
                        $past(auth_r) && state_r == swcp_pkg::st_c_busy);
  endproperty
  a_copy_valid: assert property (p_copy_valid)
    else $error("copy started without valid authorization");

  property p_copy_protect;
    (state_r == swcp_pkg::st_c_es && rx_valid_in && cp_block) |=> !copy_start_out;
  endproperty
  a_copy_protect: assert property (p_copy_protect)
    else $error("copy started into a copy-protected target");

  property p_overdrive;
    (od_clr_in || od_set_in) |=> (overdrive_flag_out == !$past(od_clr_in));
  endproperty
  a_overdrive: assert property (p_overdrive)
    else $error("overdrive flag did not follow switch requests");
endmodule
`default_nettype wire

// ==== rtl/swcp_crc16.sv ====
`include "swcp_regs.svh"
`default_nettype none
module swcp_crc16 (
  input wire logic ref_clk_in,
  input wire logic reset_n_in,
  input wire logic clr_in,
  input wire logic en_in,
  input wire logic [7:0] data_in,
  output logic [15:0] crc_out
);
  logic [15:0] crc_r;
  logic [15:0] crc_nxt;

  // clear and shift may coincide: the byte then starts a fresh sum
  always_comb begin
    crc_nxt = clr_in ? 16'h0000 : crc_r;
    if (en_in) begin
      for (int i = 0; i < 8; i++) begin
        if (crc_nxt[0] ^ data_in[i]) begin
          crc_nxt = (crc_nxt >> 1) ^ `SWCP_CRC_POLY_REV;
        end else begin
          crc_nxt = crc_nxt >> 1;
        end
      end
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      crc_r <= 16'h0000;
    end else begin
      crc_r <= crc_nxt;
    end
  end

  assign crc_out = crc_r;
endmodule
`default_nettype wire

// ==== rtl/swcp_merge.sv ====
`include "swcp_regs.svh"
`default_nettype none
module swcp_merge (
  input wire logic [15:0] addr_in,
  input wire logic [7:0] new_in,
  input wire logic [7:0] old_in,
  input wire logic [31:0] prot_codes_in,
  output logic [7:0] byte_out
);
  logic [7:0] code;

  always_comb begin
    code = `SWCP_CODE_OPEN;
    if (addr_in < `SWCP_ADDR_PROT0) begin
      code = prot_codes_in[{addr_in[6:5], 3'b000} +: 8];
    end else if (addr_in <= `SWCP_ADDR_COPY_PROT) begin
      // a protection byte holding either code locks itself
      if (old_in == `SWCP_CODE_WP || old_in == `SWCP_CODE_EPROM) begin
        code = `SWCP_CODE_WP;
      end
    end else if (addr_in == `SWCP_ADDR_FACTORY) begin
      code = `SWCP_CODE_WP;
    end
    if (code == `SWCP_CODE_WP) begin
      byte_out = old_in;
    end else if (code == `SWCP_CODE_EPROM) begin
      byte_out = new_in & old_in;
    end else begin
      byte_out = new_in;
    end
  end
endmodule
`default_nettype wire

// ==== rtl/swcp_pkg.sv ====
`default_nettype none
package swcp_pkg;
  typedef enum logic [3:0] {
    st_cmd,
    st_w_ta1,
    st_w_ta2,
    st_w_data,
    st_w_crc,
    st_r_hdr,
    st_r_data,
    st_r_crc,
    st_c_ta1,
    st_c_ta2,
    st_c_es,
    st_c_busy,
    st_c_done,
    st_idle
  } swcp_state_t;
endpackage
`default_nettype wire

// ==== rtl/swcp_regs.svh ====
`ifndef SWCP_REGS_SVH
`define SWCP_REGS_SVH

// ----------------------------------------
// memory function command codes
// ----------------------------------------
`define SWCP_CMD_WRITE_SP 8'h0f
`define SWCP_CMD_READ_SP 8'haa
`define SWCP_CMD_COPY_SP 8'h55

// ----------------------------------------
// protection codes
// ----------------------------------------
`define SWCP_CODE_WP 8'h55
`define SWCP_CODE_EPROM 8'haa
`define SWCP_CODE_OPEN 8'h00

// ----------------------------------------
// address map
// ----------------------------------------
`define SWCP_ADDR_PROT0 16'h0080
`define SWCP_ADDR_COPY_PROT 16'h0084
`define SWCP_ADDR_FACTORY 16'h0085
`define SWCP_ADDR_LIMIT 16'h0088

// ----------------------------------------
// ending offset / status byte layout
// ----------------------------------------
`define SWCP_ES_AA_BIT 7
`define SWCP_ES_PF_BIT 5
`define SWCP_ES_LAST_OFS 3'h7
`define SWCP_PF_RESET 1'b1
`define SWCP_AA_RESET 1'b0
`define SWCP_OD_RESET 1'b0

// ----------------------------------------
// data patterns
// ----------------------------------------
`define SWCP_CRC_POLY_REV 16'ha001
`define SWCP_ALT_PATTERN 8'haa
`define SWCP_IDLE_BYTE 8'hff

`endif

// ==== verification/swcp_array_model.sv ====
`default_nettype none
module swcp_array_model #(
  parameter int PROG = 20
) (
  input wire logic ref_clk_in,
  input wire logic [15:0] mem_addr_in,
  input wire logic copy_start_in,
  input wire logic [15:0] copy_addr_in,
  input wire logic [63:0] copy_data_in,
  output logic [7:0] mem_rd_data_out,
  output logic [31:0] prot_codes_out,
  output logic [7:0] copy_prot_out,
  output logic copy_done_out
);
  timeunit 1ns;
  timeprecision 1ns;
  // --------------------------------
  // eeprom rows and register row
  // --------------------------------
  logic [7:0] mem [0:143];
  logic [63:0] reg_row = 64'h0000_5500_12aa_5500;
  logic [15:0] row;
  logic [63:0] dat;
  int cnt = 0;
  initial begin
    mem_rd_data_out = 8'hff;
    copy_done_out = 1'b0;
    for (int i = 0; i < 128; i++) mem[i] = 8'(i * 37 + 5);
    for (int i = 64; i < 96; i++) mem[i] = 8'hff;
    for (int i = 0; i < 16; i++) mem[128 + i] = (i < 8) ? reg_row[8*i +: 8] : 8'hff;
  end
  assign prot_codes_out = {mem[131], mem[130], mem[129], mem[128]};
  assign copy_prot_out = mem[132];
  // programming takes a while; the row lands only when done pulses
  always @(posedge ref_clk_in) begin
    mem_rd_data_out <= (mem_addr_in < 16'h0090) ? mem[mem_addr_in] : 8'hff;
    copy_done_out <= 1'b0;
    if (copy_start_in) begin
      row = copy_addr_in;
      dat = copy_data_in;
      cnt = PROG;
    end else if (cnt > 0) begin
      cnt = cnt - 1;
      if (cnt == 0) begin
        for (int i = 0; i < 8; i++) mem[row + i] = dat[8*i +: 8];
        copy_done_out <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/test_swcp_core.sv ====
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module test_swcp_core;
  timeunit 1ns;
  timeprecision 1ns;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic xfer_end = 1'b0;
  logic rx_valid = 1'b0;
  logic tx_ready = 1'b0;
  logic od_set = 1'b0;
  logic od_clr = 1'b0;
  logic [7:0] rx_byte = 8'h00;
  logic [7:0] tx_byte, mem_rd, cprot, exp8;
  logic tx_valid, cstart, cdone, od;
  logic [15:0] maddr, caddr, crc;
  logic [15:0] ta = 16'h0000;
  logic [7:0] es = 8'h20;
  logic [31:0] prot;
  logic [63:0] cdata;
  logic [79:0] exp80;
  logic [7:0] sp [8] = '{default: 8'hff};
  logic [7:0] tx_q [$];
  logic [79:0] cp_q [$];
  int errors = 0;
  int samples_checked = 0;
  int cycles = 0;

  swcp_core swcp_core_inst (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .xfer_end_in(xfer_end), .rx_valid_in(rx_valid), .rx_byte_in(rx_byte),
    .tx_ready_in(tx_ready), .od_set_in(od_set), .od_clr_in(od_clr),
    .mem_rd_data_in(mem_rd), .prot_codes_in(prot), .copy_prot_in(cprot),
    .copy_done_in(cdone), .tx_valid_out(tx_valid), .tx_byte_out(tx_byte),
    .mem_addr_out(maddr), .copy_start_out(cstart), .copy_addr_out(caddr),
    .copy_data_out(cdata), .overdrive_flag_out(od));
  swcp_array_model swcp_array_model_inst (.ref_clk_in(ref_clk_in), .mem_addr_in(maddr),
    .copy_start_in(cstart), .copy_addr_in(caddr), .copy_data_in(cdata),
    .mem_rd_data_out(mem_rd), .prot_codes_out(prot), .copy_prot_out(cprot),
    .copy_done_out(cdone));

  always #25 ref_clk_in = ~ref_clk_in;

  // --------------------------------
  // helpers
  // --------------------------------
  function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] b);
    for (int i = 0; i < 8; i++) c = (c[0] ^ b[i]) ? ((c >> 1) ^ 16'ha001) : (c >> 1);
    return c;
  endfunction
  function automatic logic [7:0] merge(logic [15:0] a, logic [7:0] d);
    logic [7:0] o, p;
    o = swcp_array_model_inst.mem[a];
    if (a == 16'h0085) return o;
    if (a > 16'h0085) return d;
    p = (a >= 16'h0080) ? o : swcp_array_model_inst.mem[8'h80 + a[6:5]];
    if (p == 8'h55) return o;
    if (p == 8'haa) return (a >= 16'h0080) ? o : (d & o);
    return d;
  endfunction
  task automatic tick(int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask
  // bytes need three cycles between them for the array read
  task automatic send(logic [7:0] b);
    rx_byte = b;
    rx_valid = 1'b1;
    tick(1);
    rx_valid = 1'b0;
    tick(2);
  endtask
  task automatic rd(logic [7:0] e);
    tx_q.push_back(e);
    tx_ready = 1'b1;
    tick(1);
    tx_ready = 1'b0;
    tick(1);
  endtask
  task automatic fin();
    xfer_end = 1'b1;
    tick(1);
    xfer_end = 1'b0;
    tick(2);
  endtask
  task automatic wr(logic [15:0] a, int n);
    logic [7:0] d;
    send(8'h0f);
    send(a[7:0]);
    send(a[15:8]);
    crc = crc_upd(crc_upd(crc_upd(16'h0000, 8'h0f), a[7:0]), a[15:8]);
    ta = a;
    for (int i = 0; i < n; i++) begin
      d = 8'($urandom);
      sp[a[2:0] + i] = merge(a + 16'(i), d);
      crc = crc_upd(crc, d);
      send(d);
    end
    es = {2'b00, (a[2:0] + n - 1 != 7), 2'b00, 3'(a[2:0] + n - 1)};
    if (es[2:0] == 3'h7) begin
      rd(~crc[7:0]);
      rd(~crc[15:8]);
      rd(8'hff);
    end
    fin();
  endtask
  task automatic rsp();
    logic [15:0] c;
    send(8'haa);
    rd(ta[7:0]);
    rd(ta[15:8]);
    rd(es);
    c = crc_upd(crc_upd(crc_upd(crc_upd(16'h0000, 8'haa), ta[7:0]), ta[15:8]), es);
    for (int i = ta[2:0]; i <= es[2:0]; i++) begin
      rd(sp[i]);
      c = crc_upd(c, sp[i]);
    end
    rd(~c[7:0]);
    rd(~c[15:8]);
    rd(8'hff);
    fin();
  endtask
  task automatic cp(logic [7:0] e, bit ok);
    logic [63:0] v;
    for (int i = 0; i < 8; i++) v[8*i +: 8] = sp[i];
    send(8'h55);
    send(ta[7:0]);
    send(ta[15:8]);
    if (ok) cp_q.push_back({ta, v});
    send(e);
    if (ok) es[7] = 1'b1;
    tick(30);
    rd(ok ? 8'haa : 8'hff);
    fin();
  endtask
  task automatic close_out();
    if (errors == 0 && samples_checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // --------------------------------
  // result watcher and timeout
  // --------------------------------
  always @(negedge ref_clk_in) begin
    if (tx_valid === 1'b1) begin
      exp8 = (tx_q.size() > 0) ? tx_q.pop_front() : 8'hxx;
      `CHK(tx_byte, exp8)
    end
    if (cstart === 1'b1) begin
      exp80 = (cp_q.size() > 0) ? cp_q.pop_front() : 80'hx;
      `CHK({caddr, cdata}, exp80)
    end
  end
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 12000) begin
      errors++;
      close_out();
    end
  end

  initial begin
    void'($urandom(18));
    repeat (4) @(posedge ref_clk_in);
    #2;
    reset_n_in = 1'b1;
    tick(1);
    `CHK(od, 1'b0)
    rsp();
    send(8'h33);
    rd(8'hff);
    fin();
    wr(16'h0008, 8);
    rsp();
    cp(es, 1'b1);
    rsp();
    wr(16'h0040, 8);
    cp(es, 1'b1);
    wr(16'h0040, 8);
    rsp();
    wr(16'h0020, 8);
    rsp();
    cp(es, 1'b1);
    wr(16'h0080, 8);
    rsp();
    wr(16'h0010, 3);
    rsp();
    cp(es, 1'b0);
    wr(16'h0063, 5);
    rsp();
    cp(es, 1'b0);
    wr(16'h0018, 8);
    cp(es ^ 8'h01, 1'b0);
    swcp_array_model_inst.mem[132] = 8'h55;
    wr(16'h0020, 8);
    cp(es, 1'b0);
    wr(16'h0080, 8);
    cp(es, 1'b0);
    wr(16'h0060, 8);
    cp(es, 1'b1);
    od_set = 1'b1;
    tick(1);
    od_set = 1'b0;
    tick(1);
    `CHK(od, 1'b1)
    od_set = 1'b1;
    od_clr = 1'b1;
    tick(1);
    od_set = 1'b0;
    od_clr = 1'b0;
    tick(1);
    `CHK(od, 1'b0)
    // power loss in mid-run wipes the scratchpad state
    reset_n_in = 1'b0;
    tick(1);
    reset_n_in = 1'b1;
    tick(1);
    ta = 16'h0000;
    es = 8'h20;
    sp = '{default: 8'hff};
    rsp();
    `CHK(tx_q.size() + cp_q.size(), 0)
    close_out();
  end
endmodule
`default_nettype wire
